// *** src/dual_sweep_recording_control.sv ***
// Dual mode recording control: continuous FIFO, sweep capture and storage arbitration
module dual_sweep_recording_control
  import dual_sweep_pkg::*;
#(
  parameter int RATE_CYC = (RATE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS,
  parameter int MS_CYC = MS_TIME_NS / CLK_PERIOD_NS
)
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic sample_valid,
  input wire logic [DATA_W-1:0] sample_data,
  input wire logic trig_in,
  input wire logic media_full,
  output logic out_valid,
  output logic [1:0] out_kind,
  output logic [DATA_W-1:0] out_data,
  input wire logic out_ready
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    st_e st;
    logic stretch_en;
    logic delay_en;
    logic [SLEN_W-1:0] sweep_len;
    logic [SLEN_W-1:0] pre_pct;
    logic [31:0] delay_us;
    logic [31:0] rec_ms;
    logic suspended;
    logic done;
    logic [SWP_AW:0] wp;
    logic [SWP_AW:0] fp;
    logic [SWP_AW:0] ps;
    logic [SWP_AW:0] rd;
    logic rd_live;
    logic [SLEN_W-1:0] pre_cnt;
    logic [SLEN_W-1:0] post_rem;
    logic [QUE_DEPTH-1:0][SWP_AW:0] q_start;
    logic [QUE_DEPTH-1:0][SWP_AW:0] q_end;
    logic [QUE_AW:0] q_wr;
    logic [QUE_AW:0] q_rd;
    logic open;
    logic [CONT_AW:0] cw;
    logic [CONT_AW:0] cr;
    logic [TMR_W-1:0] rate_cnt;
    logic [TMR_W-1:0] str_cnt;
    logic [TMR_W-1:0] ms_pre;
    logic [31:0] ms_cnt;
    logic [US_W-1:0] us_cnt;
    logic [31:0] delay_cnt;
    logic [SCNT_W-1:0] sweep_cnt;
    logic [OCNT_W-1:0] ovr_cnt;
    logic mark_pend;
    logic note_pend;
    logic [1:0] phase;
    logic [31:0] rdata;
    logic ov;
    logic [1:0] ok;
    logic [DATA_W-1:0] od;
  } state_s;

  state_s s_r;
  state_s s_nxt;
  logic [DATA_W-1:0] swp_mem [SWP_DEPTH];
  logic [DATA_W-1:0] cont_mem [CONT_DEPTH];

  logic swp_we, cont_we, start, end_req, rec_on, take, trig, susp_now;
  logic rate_ok, acc_trig, acc_cap, stretch, ld_sweep, out_free, allow;
  logic q_empty, q_full, hd_open, cont_full, sw_avail;
  logic [SWP_AW:0] occ, free, lim, cur, cap_start;
  logic [SLEN_W-1:0] pre_len, post_len, need;
  logic [13:0] pre_prod;
  logic [QUE_AW:0] q_cnt;
  logic [QUE_AW-1:0] head;
  logic [CONT_AW:0] cont_cnt;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.rdata = '0;
    swp_we = 1'b0;
    cont_we = 1'b0;
    start = 1'b0;
    end_req = 1'b0;
    acc_trig = 1'b0;
    acc_cap = 1'b0;
    stretch = 1'b0;
    ld_sweep = 1'b0;
    susp_now = 1'b0;
    need = '0;
    cap_start = s_r.ps;
    occ = s_r.wp - s_r.fp;
    free = (SWP_AW + 1)'(SWP_DEPTH) - occ;
    pre_prod = 14'(s_r.sweep_len) * 14'(s_r.pre_pct);
    pre_len = SLEN_W'(pre_prod / 14'(PRE_PCT_MAX));
    post_len = s_r.sweep_len - pre_len;
    q_cnt = s_r.q_wr - s_r.q_rd;
    q_empty = (q_cnt == '0);
    q_full = (q_cnt == (QUE_AW + 1)'(QUE_DEPTH));
    head = s_r.q_rd[QUE_AW-1:0];
    hd_open = s_r.open && (q_cnt == (QUE_AW + 1)'(1));
    lim = hd_open ? s_r.wp : s_r.q_end[head];
    cur = s_r.rd_live ? s_r.rd : s_r.q_start[head];
    sw_avail = !q_empty && (cur != lim);
    cont_cnt = s_r.cw - s_r.cr;
    cont_full = (cont_cnt == (CONT_AW + 1)'(CONT_DEPTH));
    rec_on = (s_r.st == ST_ARMED) || (s_r.st == ST_DELAY) || (s_r.st == ST_CAPT);
    take = sample_valid && rec_on && !s_r.suspended;
    trig = trig_in && rec_on && !s_r.suspended;
    rate_ok = (s_r.rate_cnt == '0) && (s_r.sweep_cnt < SCNT_W'(MAX_SWEEPS)) && !q_full;
    out_free = !s_r.ov || out_ready;
    if (s_r.rate_cnt != '0)
      s_nxt.rate_cnt = s_r.rate_cnt - 1'b1;
    if (s_r.str_cnt != '0)
      s_nxt.str_cnt = s_r.str_cnt - 1'b1;
    s_nxt.phase = s_r.phase + 2'h1;

    // Register port
    if (reg_wr)
    begin
      case (reg_addr)
        REG_CTRL:
        begin
          s_nxt.stretch_en = reg_wdata[CTRL_STRETCH_BIT];
          s_nxt.delay_en = reg_wdata[CTRL_DELAY_BIT];
          start = reg_wdata[CTRL_RUN_BIT] && (s_r.st == ST_IDLE || s_r.st == ST_DONE);
          end_req = !reg_wdata[CTRL_RUN_BIT];
        end
        REG_SWEEP_LEN:
          if (reg_wdata == 32'h0)
            s_nxt.sweep_len = SLEN_W'(1);
          else if (reg_wdata > 32'(SWP_DEPTH))
            s_nxt.sweep_len = SLEN_W'(SWP_DEPTH);
          else
            s_nxt.sweep_len = reg_wdata[SLEN_W-1:0];
        REG_PRE_PCT:
          s_nxt.pre_pct = (reg_wdata > 32'(PRE_PCT_MAX)) ? SLEN_W'(PRE_PCT_MAX)
                                                         : reg_wdata[SLEN_W-1:0];
        REG_DELAY_US:
          s_nxt.delay_us = (reg_wdata > 32'(DELAY_MAX_US)) ? 32'(DELAY_MAX_US) : reg_wdata;
        REG_REC_MS:
          s_nxt.rec_ms = reg_wdata;
        default:
          ;
      endcase
    end
    if (reg_rd)
    begin
      case (reg_addr)
        REG_CTRL:
          s_nxt.rdata = {29'h0, s_r.delay_en, s_r.stretch_en, rec_on};
        REG_SWEEP_LEN:
          s_nxt.rdata = 32'(s_r.sweep_len);
        REG_PRE_PCT:
          s_nxt.rdata = 32'(s_r.pre_pct);
        REG_DELAY_US:
          s_nxt.rdata = s_r.delay_us;
        REG_REC_MS:
          s_nxt.rdata = s_r.rec_ms;
        REG_STATUS:
          s_nxt.rdata = {27'h0, s_r.st == ST_CAPT, s_r.st == ST_DELAY, s_r.done,
                         s_r.suspended, rec_on};
        REG_SWEEP_CNT:
          s_nxt.rdata = 32'(s_r.sweep_cnt);
        REG_OVR_CNT:
          s_nxt.rdata = 32'(s_r.ovr_cnt);
        default:
          s_nxt.rdata = '0;
      endcase
    end

    // Storage arbiter: notes, markers, continuous, then sweep only once the continuous FIFO is empty
    if (cont_cnt >= (CONT_AW + 1)'(CONT_DEPTH * 3 / 4))
      allow = 1'b0;
    else if (cont_cnt >= (CONT_AW + 1)'(CONT_DEPTH / 2))
      allow = (s_r.phase == 2'h0);
    else if (cont_cnt >= (CONT_AW + 1)'(CONT_DEPTH / 4))
      allow = !s_r.phase[0];
    else
      allow = 1'b1;
    if (s_r.ov && out_ready)
      s_nxt.ov = 1'b0;
    if (out_free)
    begin
      if (s_r.note_pend)
      begin
        s_nxt.ov = 1'b1;
        s_nxt.ok = KIND_NOTE;
        s_nxt.od = DATA_W'(s_r.ovr_cnt);
        s_nxt.note_pend = 1'b0;
      end
      else if (s_r.mark_pend)
      begin
        s_nxt.ov = 1'b1;
        s_nxt.ok = KIND_MARK;
        s_nxt.od = DATA_W'(s_r.sweep_cnt);
        s_nxt.mark_pend = 1'b0;
      end
      else if (cont_cnt != '0)
      begin
        s_nxt.ov = 1'b1;
        s_nxt.ok = KIND_CONT;
        s_nxt.od = cont_mem[s_r.cr[CONT_AW-1:0]];
        s_nxt.cr = s_r.cr + 1'b1;
      end
      else if (sw_avail && allow)
      begin
        ld_sweep = 1'b1;
        s_nxt.ov = 1'b1;
        s_nxt.ok = KIND_SWEEP;
        s_nxt.od = swp_mem[cur[SWP_AW-1:0]];
        s_nxt.rd = cur + 1'b1;
        s_nxt.rd_live = 1'b1;
      end
    end

    // Sweep memory release
    if (q_empty)
      s_nxt.fp = s_r.ps;
    else if (!hd_open && (cur == lim) && !ld_sweep)
    begin
      s_nxt.q_rd = s_r.q_rd + 1'b1;
      s_nxt.rd_live = 1'b0;
      s_nxt.fp = (q_cnt > (QUE_AW + 1)'(1)) ? s_r.q_start[head + QUE_AW'(1)] : s_r.ps;
    end

    // Recording
    if (start)
    begin
      s_nxt.st = ST_ARMED;
      s_nxt.done = 1'b0;
      s_nxt.suspended = 1'b0;
      s_nxt.wp = '0;
      s_nxt.fp = '0;
      s_nxt.ps = '0;
      s_nxt.rd_live = 1'b0;
      s_nxt.pre_cnt = '0;
      s_nxt.q_wr = '0;
      s_nxt.q_rd = '0;
      s_nxt.open = 1'b0;
      s_nxt.cw = '0;
      s_nxt.cr = '0;
      s_nxt.rate_cnt = '0;
      s_nxt.str_cnt = '0;
      s_nxt.ms_pre = '0;
      s_nxt.ms_cnt = '0;
      s_nxt.sweep_cnt = '0;
      s_nxt.ovr_cnt = '0;
      s_nxt.mark_pend = 1'b0;
      s_nxt.note_pend = 1'b0;
    end
    else if (rec_on)
    begin
      end_req = end_req || media_full ||
                (s_r.rec_ms != 32'h0 && s_r.ms_cnt >= s_r.rec_ms);
      if (s_r.ms_pre == TMR_W'(MS_CYC - 1))
      begin
        s_nxt.ms_pre = '0;
        s_nxt.ms_cnt = s_r.ms_cnt + 32'h1;
      end
      else
        s_nxt.ms_pre = s_r.ms_pre + 1'b1;
      if (trig)
        s_nxt.mark_pend = 1'b1;
      case (s_r.st)
        ST_ARMED:
          if (trig && rate_ok)
          begin
            acc_trig = 1'b1;
            s_nxt.rate_cnt = TMR_W'(RATE_CYC - 1);
            if (s_r.delay_en)
            begin
              s_nxt.st = ST_DELAY;
              s_nxt.delay_cnt = s_r.delay_us;
              s_nxt.us_cnt = US_W'(US_CYC - 1);
              s_nxt.pre_cnt = '0;
              s_nxt.ps = s_r.wp;
            end
            else
            begin
              need = post_len;
              acc_cap = (free >= post_len);
            end
          end
        ST_DELAY:
          if (s_r.us_cnt != '0)
            s_nxt.us_cnt = s_r.us_cnt - 1'b1;
          else if (s_r.delay_cnt != 32'h0)
          begin
            s_nxt.us_cnt = US_W'(US_CYC - 1);
            s_nxt.delay_cnt = s_r.delay_cnt - 32'h1;
          end
          else
          begin
            need = s_r.sweep_len;
            cap_start = s_r.wp;
            acc_cap = (free >= s_r.sweep_len);
            if (!acc_cap)
              s_nxt.st = ST_ARMED;
          end
        ST_CAPT:
          if (trig && s_r.stretch_en && s_r.str_cnt == '0 && free >= post_len)
          begin
            stretch = 1'b1;
            s_nxt.post_rem = post_len;
            s_nxt.str_cnt = TMR_W'(RATE_CYC - 1);
          end
        default:
          ;
      endcase
      if (acc_cap)
      begin
        s_nxt.q_start[s_r.q_wr[QUE_AW-1:0]] = cap_start;
        s_nxt.q_wr = s_r.q_wr + 1'b1;
        s_nxt.open = 1'b1;
        s_nxt.sweep_cnt = s_r.sweep_cnt + 1'b1;
        s_nxt.st = ST_CAPT;
        s_nxt.post_rem = (s_r.st == ST_DELAY) ? s_r.sweep_len : post_len;
      end
      // Continuous FIFO; full FIFO suspends sample and trigger intake for both recordings
      if (take && cont_full)
      begin
        susp_now = 1'b1;
        s_nxt.suspended = 1'b1;
        s_nxt.note_pend = 1'b1;
        s_nxt.ovr_cnt = s_r.ovr_cnt + 1'b1;
        s_nxt.post_rem = '0;
        if (s_nxt.st == ST_DELAY)
          s_nxt.st = ST_ARMED;
      end
      else if (take)
      begin
        cont_we = 1'b1;
        s_nxt.cw = s_r.cw + 1'b1;
      end
      // Sweep memory writes
      if (take && !susp_now && s_nxt.st == ST_CAPT && s_nxt.post_rem != '0)
      begin
        swp_we = 1'b1;
        s_nxt.wp = s_r.wp + 1'b1;
        s_nxt.post_rem = s_nxt.post_rem - 1'b1;
      end
      else if (take && !susp_now && s_nxt.st == ST_ARMED)
      begin
        if (free != '0)
        begin
          swp_we = 1'b1;
          s_nxt.wp = s_r.wp + 1'b1;
          if (s_r.pre_cnt >= pre_len)
            s_nxt.ps = s_r.ps + 1'b1;
          else
            s_nxt.pre_cnt = s_r.pre_cnt + 1'b1;
        end
        else
        begin
          s_nxt.pre_cnt = '0;
          s_nxt.ps = s_r.wp;
        end
      end
      if (susp_now && s_nxt.st == ST_ARMED)
      begin
        s_nxt.pre_cnt = '0;
        s_nxt.ps = s_nxt.wp;
      end
      // Close the sweep being captured
      if (s_nxt.st == ST_CAPT && (s_nxt.post_rem == '0 || end_req))
      begin
        s_nxt.q_end[s_nxt.q_wr[QUE_AW-1:0] - QUE_AW'(1)] = s_nxt.wp;
        s_nxt.open = 1'b0;
        s_nxt.st = ST_ARMED;
        s_nxt.pre_cnt = '0;
        s_nxt.ps = s_nxt.wp;
      end
      if (end_req)
        s_nxt.st = ST_FINISH;
    end
    else if (s_r.st == ST_FINISH && cont_cnt == '0 && q_empty && !s_r.ov &&
             !s_r.mark_pend && !s_r.note_pend)
    begin
      s_nxt.st = ST_DONE;
      s_nxt.done = 1'b1;
    end
    if (s_r.suspended && cont_cnt == '0 && occ == '0 && q_empty)
      s_nxt.suspended = 1'b0;

    if (reset)
    begin
      s_nxt = '0;
      s_nxt.st = ST_IDLE;
      s_nxt.sweep_len = SWEEP_LEN_RST;
      s_nxt.pre_pct = PRE_PCT_RST;
      s_nxt.delay_us = DELAY_US_RST;
      s_nxt.rec_ms = REC_MS_RST;
      swp_we = 1'b0;
      cont_we = 1'b0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    s_r <= s_nxt;
  end

  // ----------------------------------------------------------------
  // Sample memories
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (swp_we)
      swp_mem[s_r.wp[SWP_AW-1:0]] <= sample_data;
    if (cont_we)
      cont_mem[s_r.cw[CONT_AW-1:0]] <= sample_data;
  end

  assign reg_rdata = s_r.rdata;
  assign out_valid = s_r.ov;
  assign out_kind = s_r.ok;
  assign out_data = s_r.od;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  sequence rate_reload;
    s_r.rate_cnt == TMR_W'(RATE_CYC - 1);
  endsequence
  sequence str_reload;
    s_r.str_cnt == TMR_W'(RATE_CYC - 1);
  endsequence

  prio_cont_a: assert property (ld_sweep |-> cont_cnt == '0)
    else $error("sweep word loaded while continuous data waits");
  rate_gap_a: assert property (acc_trig |-> s_r.rate_cnt == '0 ##1 rate_reload)
    else $error("sweep accepted inside rate interval");
  stretch_gap_a: assert property (stretch |-> s_r.str_cnt == '0 ##1 str_reload)
    else $error("stretch inside stretch interval");
  sweep_max_a: assert property (acc_cap |-> s_r.sweep_cnt < SCNT_W'(MAX_SWEEPS))
    else $error("sweep count limit exceeded");
  need_room_a: assert property (acc_cap |-> free >= need)
    else $error("sweep started without room");
  pre_trunc_a: assert property (s_r.st == ST_ARMED |-> s_r.wp - s_r.ps == s_r.pre_cnt)
    else $error("pre-trigger window differs from captured samples");
  susp_full_a: assert property (take && cont_full |=> s_r.suspended && s_r.note_pend)
    else $error("full continuous FIFO did not suspend");
  resume_a: assert property (s_r.suspended && cont_cnt == '0 && occ == '0 && q_empty
                             |=> !s_r.suspended)
    else $error("recording did not resume when memories empty");
  note_first_a: assert property (s_r.note_pend && out_free |=> s_r.ov && s_r.ok == KIND_NOTE)
    else $error("overrun note not placed in storage stream");

endmodule

// *** shared/dual_sweep_pkg.sv ***
// Constants, register map and state encoding for the dual sweep recording controller
package dual_sweep_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int US_TIME_NS = 1000;
  localparam int US_CYC = (US_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MS_TIME_NS = 1000000;
  localparam int RATE_TIME_NS = 2500000;
  localparam int DELAY_MAX_S = 1000;
  localparam int DELAY_MAX_US = DELAY_MAX_S * 1000000;
  localparam int TMR_W = 20;
  localparam int US_W = 7;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int DATA_W = 16;
  localparam int SWP_AW = 6;
  localparam int SWP_DEPTH = 1 << SWP_AW;
  localparam int SLEN_W = SWP_AW + 1;
  localparam int CONT_AW = 4;
  localparam int CONT_DEPTH = 1 << CONT_AW;
  localparam int QUE_AW = 2;
  localparam int QUE_DEPTH = 1 << QUE_AW;
  localparam int PRE_PCT_MAX = 100;
  localparam int MAX_SWEEPS = 200000;
  localparam int SCNT_W = 18;
  localparam int OCNT_W = 16;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_SWEEP_LEN = 8'h04;
  localparam logic [7:0] REG_PRE_PCT = 8'h08;
  localparam logic [7:0] REG_DELAY_US = 8'h0c;
  localparam logic [7:0] REG_REC_MS = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam logic [7:0] REG_SWEEP_CNT = 8'h18;
  localparam logic [7:0] REG_OVR_CNT = 8'h1c;

  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_STRETCH_BIT = 1;
  localparam int CTRL_DELAY_BIT = 2;

  localparam logic [SLEN_W-1:0] SWEEP_LEN_RST = 7'h20;
  localparam logic [SLEN_W-1:0] PRE_PCT_RST = 7'h00;
  localparam logic [31:0] DELAY_US_RST = 32'h0;
  localparam logic [31:0] REC_MS_RST = 32'h0;

  // ----------------------------------------------------------------
  // Storage word kinds and states
  // ----------------------------------------------------------------
  localparam logic [1:0] KIND_CONT = 2'h0;
  localparam logic [1:0] KIND_SWEEP = 2'h1;
  localparam logic [1:0] KIND_MARK = 2'h2;
  localparam logic [1:0] KIND_NOTE = 2'h3;

  typedef enum logic [2:0] {ST_IDLE, ST_ARMED, ST_DELAY, ST_CAPT, ST_FINISH, ST_DONE} st_e;

endpackage

// *** tb/storage_sink_model.sv ***
// Storage path model that accepts words promptly, slowly or not at all
module storage_sink_model
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic stall,
  input wire logic slow,
  output logic out_ready
);
  timeunit 1ns;
  timeprecision 1ps;

  logic phase_r;

  // ----------------------------------------------------------------
  // Slow mode accepts every other cycle
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      phase_r <= 1'b0;
    else
      phase_r <= ~phase_r;
  end

  assign out_ready = ~reset & ~stall & (~slow | phase_r);
endmodule

// *** tb/dual_sweep_recording_control_tb.sv ***
// Self-checking bench for the dual sweep recording controller
module dual_sweep_recording_control_tb import dual_sweep_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {logic [7:0] a; bit w; logic [31:0] d; logic [31:0] e;} row_s;

  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic sample_valid = 1'b0;
  logic [DATA_W-1:0] sample_data = 16'h0;
  logic trig_in = 1'b0;
  logic media_full = 1'b0;
  logic out_valid;
  logic [1:0] out_kind;
  logic [DATA_W-1:0] out_data;
  logic out_ready;
  logic stall = 1'b0;
  logic slow = 1'b0;
  logic [DATA_W-1:0] last_cont = 16'h0;
  logic [31:0] rv;
  int n_mismatch = 0;
  int check_count = 0;
  int kcnt[4] = '{0, 0, 0, 0};
  int base;

  row_s rows[16] = '{
    '{REG_CTRL, 0, 32'h0, 32'h0}, '{REG_SWEEP_LEN, 0, 32'h0, 32'h20},
    '{REG_PRE_PCT, 0, 32'h0, 32'h0}, '{REG_DELAY_US, 0, 32'h0, 32'h0},
    '{REG_REC_MS, 0, 32'h0, 32'h0}, '{REG_STATUS, 0, 32'h0, 32'h0},
    '{REG_SWEEP_CNT, 0, 32'h0, 32'h0}, '{REG_OVR_CNT, 0, 32'h0, 32'h0},
    '{8'h40, 0, 32'h0, 32'h0}, '{REG_PRE_PCT, 1, 32'h96, 32'h64},
    '{REG_PRE_PCT, 1, 32'h64, 32'h64}, '{REG_SWEEP_LEN, 1, 32'h0, 32'h1},
    '{REG_SWEEP_LEN, 1, 32'h64, 32'h40}, '{REG_DELAY_US, 1, 32'hffffffff, 32'h3b9aca00},
    '{8'h40, 1, 32'h5a, 32'h0}, '{REG_SWEEP_CNT, 1, 32'h5, 32'h0}};

  always #5 clk_sys = ~clk_sys;

  dual_sweep_recording_control #(.RATE_CYC(50), .MS_CYC(20)) i_dut (
    .clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sample_valid(sample_valid), .sample_data(sample_data), .trig_in(trig_in),
    .media_full(media_full), .out_valid(out_valid), .out_kind(out_kind),
    .out_data(out_data), .out_ready(out_ready));

  storage_sink_model i_sink (
    .clk_sys(clk_sys), .reset(reset), .stall(stall), .slow(slow), .out_ready(out_ready));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("Mismatches %0d, checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(posedge clk_sys);
    rv = reg_rdata;
  endtask

  task automatic samp(input int n, input int t, input int t2 = -1);
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk_sys);
      sample_valid <= 1'b1;
      sample_data <= sample_data + 16'h1;
      trig_in <= (i == t) || (i == t2);
    end
    @(posedge clk_sys);
    sample_valid <= 1'b0;
    trig_in <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Storage word monitor
  // ----------------------------------------------------------------
  always @(posedge clk_sys)
  begin
    if (!reset && out_valid === 1'b1 && out_ready === 1'b1)
    begin
      kcnt[out_kind] <= kcnt[out_kind] + 1;
      if (out_kind === KIND_CONT)
      begin
        chk(out_data > last_cont, 32'h1, "continuous order");
        last_cont <= out_data;
      end
    end
  end

  initial
  begin
    #100000;
    n_mismatch++;
    print_verdict();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    idle(2);
    reset <= 1'b0;
    foreach (rows[i])
    begin
      if (rows[i].w)
        wr(rows[i].a, rows[i].d);
      rd(rows[i].a);
      chk(rv, rows[i].e, "register row");
    end
    wr(REG_SWEEP_LEN, 32'h8);
    wr(REG_PRE_PCT, 32'h32);
    wr(REG_CTRL, 32'h1);
    rd(REG_STATUS);
    chk(rv[0], 32'h1, "recording");
    samp(10, 2);
    idle(25);
    chk(kcnt[1], 32'h6, "short pre sweep words");
    chk(kcnt[2], 32'h1, "first marker");
    samp(6, 1);
    idle(20);
    chk(kcnt[1], 32'h6, "rate limited sweep");
    chk(kcnt[2], 32'h2, "rate limited marker");
    rd(REG_SWEEP_CNT);
    chk(rv, 32'h1, "sweep count");
    idle(60);
    samp(8, 0);
    idle(30);
    rd(REG_SWEEP_CNT);
    chk(rv, 32'h2, "sweep after gap");
    // Overrun of the continuous FIFO
    stall <= 1'b1;
    samp(20, -1);
    rd(REG_STATUS);
    chk(rv[1], 32'h1, "suspended");
    stall <= 1'b0;
    slow <= 1'b1;
    idle(80);
    rd(REG_STATUS);
    chk(rv[1], 32'h0, "resumed");
    chk(kcnt[3], 32'h1, "overrun note");
    rd(REG_OVR_CNT);
    chk(rv, 32'h1, "overrun count");
    // Delayed trigger, whole sweep after the delay
    slow <= 1'b0;
    base = kcnt[1];
    wr(REG_DELAY_US, 32'h1);
    wr(REG_CTRL, 32'h5);
    samp(3, 0);
    rd(REG_STATUS);
    chk(rv[3], 32'h1, "in delay");
    samp(220, -1);
    idle(30);
    chk(kcnt[1] - base, 32'h8, "delayed sweep words");
    // Stretch: second trigger in post segment restarts the post count
    wr(REG_CTRL, 32'h3);
    base = kcnt[1];
    samp(12, 0, 2);
    idle(30);
    chk(kcnt[1] - base, 32'ha, "stretched sweep words");
    // Ends of recording
    wr(REG_CTRL, 32'h0);
    idle(40);
    rd(REG_STATUS);
    chk(rv, 32'h4, "stopped");
    wr(REG_CTRL, 32'h1);
    samp(3, -1);
    media_full <= 1'b1;
    idle(40);
    rd(REG_STATUS);
    chk(rv, 32'h4, "media full");
    media_full <= 1'b0;
    wr(REG_REC_MS, 32'h1);
    wr(REG_CTRL, 32'h1);
    rd(REG_STATUS);
    chk(rv[0], 32'h1, "timed run");
    idle(40);
    rd(REG_STATUS);
    chk(rv, 32'h4, "time elapsed");
    print_verdict();
  end
endmodule
